// ### shared/tap_pkg.sv
package tap_pkg;

   // ****************************************
   // Instruction register
   // ****************************************
   localparam int                  IR_W       = 4;
   localparam logic [IR_W-1:0]     OP_EXTEST  = 4'h0;
   localparam logic [IR_W-1:0]     OP_SAMPLE  = 4'h1;
   localparam logic [IR_W-1:0]     OP_IDCODE  = 4'h2;
   localparam logic [IR_W-1:0]     OP_CLAMP   = 4'h3;
   localparam logic [IR_W-1:0]     OP_INTEST  = 4'h4;
   localparam logic [IR_W-1:0]     OP_PRIVATE = 4'h8;
   localparam logic [IR_W-1:0]     OP_BYPASS  = 4'hF;
   localparam logic [IR_W-1:0]     IR_CAPTURE = 4'h1;

   // ****************************************
   // Data registers
   // ****************************************
   localparam int                  ID_W       = 32;
   localparam logic                ID_MARK    = 1'h1;
   localparam logic                BYP_CAPT   = 1'h0;
   localparam int                  PRIV_W     = 8;
   localparam logic [PRIV_W-1:0]   PRIV_RESET = 8'h00;

   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [3:0] {
      TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
      SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
   } tap_state_e;

   typedef struct packed {
      logic sel_byp;
      logic sel_id;
      logic sel_bsr;
      logic sel_priv;
      logic drive;
      logic intest;
   } tap_mode_s;

   // Undefined codes fall back to bypass
   function automatic tap_mode_s decode_op(input logic [IR_W-1:0] op);
      tap_mode_s m;
      m = '0;
      case (op)
         OP_EXTEST: begin
            m.sel_bsr = 1'b1;
            m.drive   = 1'b1;
         end
         OP_SAMPLE:  m.sel_bsr  = 1'b1;
         OP_IDCODE:  m.sel_id   = 1'b1;
         OP_CLAMP: begin
            m.sel_byp = 1'b1;
            m.drive   = 1'b1;
         end
         OP_INTEST: begin
            m.sel_bsr = 1'b1;
            m.intest  = 1'b1;
         end
         OP_PRIVATE: m.sel_priv = 1'b1;
         default:    m.sel_byp  = 1'b1;
      endcase
      return m;
   endfunction

endpackage

// ### verilog/sync_2ff.sv
`timescale 1ns/100ps
module sync_2ff #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         en,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] meta_r;
   logic [W-1:0] meta_nxt;
   logic [W-1:0] q_r;
   logic [W-1:0] q_nxt;

   always_comb begin
      meta_nxt = meta_r;
      q_nxt    = q_r;
      if (!rst_n) begin
         meta_nxt = '0;
         q_nxt    = '0;
      end else if (en) begin
         meta_nxt = d;
         q_nxt    = meta_r;
      end
   end

   always_ff @(posedge clk) begin
      meta_r <= meta_nxt;
      q_r    <= q_nxt;
   end

   assign q = q_r;

endmodule

// ### verilog/boundary_scan_tap.sv
`timescale 1ns/100ps
module boundary_scan_tap #(
   parameter int          N_IN    = 8,
   parameter int          N_OUT   = 8,
   parameter logic [3:0]  ID_VER  = 4'h1,    // Arbitrary value
   parameter logic [15:0] ID_PART = 16'h0001, // Arbitrary value
   parameter logic [10:0] ID_MAKR = 11'h001  // Arbitrary value
) (
   input  wire logic             ref_clk,
   input  wire logic             rstn,
   input  wire logic             ce,
   input  wire logic             tck,
   input  wire logic             trst_n,
   input  wire logic             tms,
   input  wire logic             tdi,
   output logic                  tdo,
   output logic                  tdo_oe,
   input  wire logic [N_IN-1:0]  pad_in,
   input  wire logic [N_OUT-1:0] core_out,
   output logic      [N_IN-1:0]  core_in,
   output logic      [N_OUT-1:0] pad_out
);

   localparam int L = N_IN + N_OUT;
   localparam logic [tap_pkg::ID_W-1:0] IDCODE = {ID_VER, ID_PART, ID_MAKR, tap_pkg::ID_MARK};

   // ****************************************
   // Test clock domain state
   // ****************************************
   tap_pkg::tap_state_e            state_r, state_nxt;
   logic [tap_pkg::IR_W-1:0]       ir_sh_r, ir_sh_nxt;
   logic [tap_pkg::IR_W-1:0]       ir_r, ir_nxt;
   tap_pkg::tap_mode_s             mode_r, mode_nxt;
   logic                           byp_r, byp_nxt;
   logic [tap_pkg::ID_W-1:0]       id_sh_r, id_sh_nxt;
   logic [L-1:0]                   bsr_sh_r, bsr_sh_nxt;
   logic [L-1:0]                   bsr_upd_r, bsr_upd_nxt;
   logic [tap_pkg::PRIV_W-1:0]     priv_sh_r, priv_sh_nxt;
   logic [tap_pkg::PRIV_W-1:0]     priv_r, priv_nxt;
   logic                           tog_r, tog_nxt;
   logic                           tdo_r, tdo_nxt;
   logic                           oe_r, oe_nxt;
   logic                           shifting;
   logic                           tdo_mux;
   logic [N_IN-1:0]                pad_t;
   logic [N_OUT-1:0]               core_t;
   logic [N_OUT-1:0]               pad_out_r, pad_out_nxt;

   // Functional side values seen from the test clock
   sync_2ff #(.W(N_IN)) u_pad_t (
      .clk   (tck),
      .rst_n (trst_n),
      .en    (1'b1),
      .d     (pad_in),
      .q     (pad_t)
   );

   sync_2ff #(.W(N_OUT)) u_core_t (
      .clk   (tck),
      .rst_n (trst_n),
      .en    (1'b1),
      .d     (pad_out_r),
      .q     (core_t)
   );

   function automatic tap_pkg::tap_state_e tap_next(input tap_pkg::tap_state_e s, input logic m);
      tap_pkg::tap_state_e n;
      n = tap_pkg::TLR;
      case (s)
         tap_pkg::TLR:    n = m ? tap_pkg::TLR    : tap_pkg::RTI;
         tap_pkg::RTI:    n = m ? tap_pkg::SEL_DR : tap_pkg::RTI;
         tap_pkg::SEL_DR: n = m ? tap_pkg::SEL_IR : tap_pkg::CAP_DR;
         tap_pkg::CAP_DR: n = m ? tap_pkg::EX1_DR : tap_pkg::SH_DR;
         tap_pkg::SH_DR:  n = m ? tap_pkg::EX1_DR : tap_pkg::SH_DR;
         tap_pkg::EX1_DR: n = m ? tap_pkg::UPD_DR : tap_pkg::PAU_DR;
         tap_pkg::PAU_DR: n = m ? tap_pkg::EX2_DR : tap_pkg::PAU_DR;
         tap_pkg::EX2_DR: n = m ? tap_pkg::UPD_DR : tap_pkg::SH_DR;
         tap_pkg::UPD_DR: n = m ? tap_pkg::SEL_DR : tap_pkg::RTI;
         tap_pkg::SEL_IR: n = m ? tap_pkg::TLR    : tap_pkg::CAP_IR;
         tap_pkg::CAP_IR: n = m ? tap_pkg::EX1_IR : tap_pkg::SH_IR;
         tap_pkg::SH_IR:  n = m ? tap_pkg::EX1_IR : tap_pkg::SH_IR;
         tap_pkg::EX1_IR: n = m ? tap_pkg::UPD_IR : tap_pkg::PAU_IR;
         tap_pkg::PAU_IR: n = m ? tap_pkg::EX2_IR : tap_pkg::PAU_IR;
         tap_pkg::EX2_IR: n = m ? tap_pkg::UPD_IR : tap_pkg::SH_IR;
         tap_pkg::UPD_IR: n = m ? tap_pkg::SEL_DR : tap_pkg::RTI;
         default:         n = tap_pkg::TLR;
      endcase
      return n;
   endfunction

   always_comb begin
      state_nxt   = tap_next(state_r, tms);
      ir_sh_nxt   = ir_sh_r;
      ir_nxt      = ir_r;
      byp_nxt     = byp_r;
      id_sh_nxt   = id_sh_r;
      bsr_sh_nxt  = bsr_sh_r;
      bsr_upd_nxt = bsr_upd_r;
      priv_sh_nxt = priv_sh_r;
      priv_nxt    = priv_r;
      tog_nxt     = tog_r;
      case (state_r)
         tap_pkg::TLR:    ir_nxt = tap_pkg::OP_IDCODE;
         tap_pkg::CAP_IR: ir_sh_nxt = tap_pkg::IR_CAPTURE;
         tap_pkg::SH_IR:  ir_sh_nxt = {tdi, ir_sh_r[tap_pkg::IR_W-1:1]};
         tap_pkg::UPD_IR: ir_nxt = ir_sh_r;
         tap_pkg::CAP_DR: begin
            if (mode_r.sel_byp)
               byp_nxt = tap_pkg::BYP_CAPT;
            if (mode_r.sel_id)
               id_sh_nxt = IDCODE;
            if (mode_r.sel_bsr)
               bsr_sh_nxt = {core_t, pad_t};
            if (mode_r.sel_priv)
               priv_sh_nxt = priv_r;
         end
         tap_pkg::SH_DR: begin
            if (mode_r.sel_byp)
               byp_nxt = tdi;
            if (mode_r.sel_id)
               id_sh_nxt = {tdi, id_sh_r[tap_pkg::ID_W-1:1]};
            if (mode_r.sel_bsr)
               bsr_sh_nxt = {tdi, bsr_sh_r[L-1:1]};
            if (mode_r.sel_priv)
               priv_sh_nxt = {tdi, priv_sh_r[tap_pkg::PRIV_W-1:1]};
         end
         tap_pkg::UPD_DR: begin
            if (mode_r.sel_bsr) begin
               bsr_upd_nxt = bsr_sh_r;
               tog_nxt     = ~tog_r;
            end
            if (mode_r.sel_priv)
               priv_nxt = priv_sh_r;
         end
         default: ;
      endcase
      mode_nxt = tap_pkg::decode_op(ir_nxt);
   end

   // Test reset acts without the test clock
   always_ff @(posedge tck or negedge trst_n) begin
      if (!trst_n) begin
         state_r   <= tap_pkg::TLR;
         ir_sh_r   <= tap_pkg::IR_CAPTURE;
         ir_r      <= tap_pkg::OP_IDCODE;
         mode_r    <= tap_pkg::tap_mode_s'{sel_id: 1'b1, default: 1'b0};
         byp_r     <= tap_pkg::BYP_CAPT;
         id_sh_r   <= '0;
         bsr_sh_r  <= '0;
         bsr_upd_r <= '0;
         priv_sh_r <= tap_pkg::PRIV_RESET;
         priv_r    <= tap_pkg::PRIV_RESET;
         tog_r     <= 1'b0;
      end else begin
         state_r   <= state_nxt;
         ir_sh_r   <= ir_sh_nxt;
         ir_r      <= ir_nxt;
         mode_r    <= mode_nxt;
         byp_r     <= byp_nxt;
         id_sh_r   <= id_sh_nxt;
         bsr_sh_r  <= bsr_sh_nxt;
         bsr_upd_r <= bsr_upd_nxt;
         priv_sh_r <= priv_sh_nxt;
         priv_r    <= priv_nxt;
         tog_r     <= tog_nxt;
      end
   end

   // ****************************************
   // Serial output on the falling edge
   // ****************************************
   always_comb begin
      shifting = (state_r == tap_pkg::SH_DR) || (state_r == tap_pkg::SH_IR);
      if (state_r == tap_pkg::SH_IR)
         tdo_mux = ir_sh_r[0];
      else if (mode_r.sel_id)
         tdo_mux = id_sh_r[0];
      else if (mode_r.sel_bsr)
         tdo_mux = bsr_sh_r[0];
      else if (mode_r.sel_priv)
         tdo_mux = priv_sh_r[0];
      else
         tdo_mux = byp_r;
      tdo_nxt = shifting ? tdo_mux : 1'b0;
      oe_nxt  = shifting;
   end

   // Half a test clock of hold time for the tester
   always_ff @(negedge tck or negedge trst_n) begin
      if (!trst_n) begin
         tdo_r <= 1'b0;
         oe_r  <= 1'b0;
      end else begin
         tdo_r <= tdo_nxt;
         oe_r  <= oe_nxt;
      end
   end

   assign tdo    = tdo_r;
   assign tdo_oe = oe_r;

   // ****************************************
   // Functional clock domain
   // ****************************************
   logic [1:0]       mode_s;
   logic             tog_s;
   logic [N_IN-1:0]  pad_s;
   logic             tog_d_r, tog_d_nxt;
   logic [L-1:0]     hold_r, hold_nxt;
   logic [N_IN-1:0]  core_in_r, core_in_nxt;

   sync_2ff #(.W(2)) u_mode_s (
      .clk   (ref_clk),
      .rst_n (rstn),
      .en    (ce),
      .d     ({mode_r.drive, mode_r.intest}),
      .q     (mode_s)
   );

   sync_2ff #(.W(1)) u_tog_s (
      .clk   (ref_clk),
      .rst_n (rstn),
      .en    (ce),
      .d     (tog_r),
      .q     (tog_s)
   );

   sync_2ff #(.W(N_IN)) u_pad_s (
      .clk   (ref_clk),
      .rst_n (rstn),
      .en    (ce),
      .d     (pad_in),
      .q     (pad_s)
   );

   // Update latches are stable for a whole scan after the toggle moves
   always_comb begin
      tog_d_nxt   = tog_d_r;
      hold_nxt    = hold_r;
      core_in_nxt = core_in_r;
      pad_out_nxt = pad_out_r;
      if (!rstn) begin
         tog_d_nxt   = 1'b0;
         hold_nxt    = '0;
         core_in_nxt = '0;
         pad_out_nxt = '0;
      end else if (ce) begin
         tog_d_nxt   = tog_s;
         if (tog_s != tog_d_r)
            hold_nxt = bsr_upd_r;
         core_in_nxt = mode_s[0] ? hold_r[N_IN-1:0] : pad_s;
         pad_out_nxt = mode_s[1] ? hold_r[L-1:N_IN] : core_out;
      end
   end

   always_ff @(posedge ref_clk) begin
      tog_d_r   <= tog_d_nxt;
      hold_r    <= hold_nxt;
      core_in_r <= core_in_nxt;
      pad_out_r <= pad_out_nxt;
   end

   assign core_in = core_in_r;
   assign pad_out = pad_out_r;

   // ****************************************
   // Assertions
   // ****************************************
   property p_tlr_five;
      @(posedge tck) disable iff (!trst_n) tms [*5] |=> state_r == tap_pkg::TLR;
   endproperty
   a_tlr_five: assert property (p_tlr_five) else $error("five mode highs did not reach reset state");

   property p_tlr_ir;
      @(posedge tck) disable iff (!trst_n) state_r == tap_pkg::TLR |=> ir_r == tap_pkg::OP_IDCODE;
   endproperty
   a_tlr_ir: assert property (p_tlr_ir) else $error("reset state did not load identification");

   property p_id_cap;
      @(posedge tck) disable iff (!trst_n)
         (state_r == tap_pkg::CAP_DR && ir_r == tap_pkg::OP_IDCODE) |=> id_sh_r == IDCODE;
   endproperty
   a_id_cap: assert property (p_id_cap) else $error("identification code not captured");

   property p_id_lsb;
      @(posedge tck) disable iff (!trst_n)
         (state_r == tap_pkg::SH_DR && ir_r == tap_pkg::OP_IDCODE) |-> tdo == id_sh_r[0];
   endproperty
   a_id_lsb: assert property (p_id_lsb) else $error("identification path not lsb first");

   property p_byp_one;
      @(posedge tck) disable iff (!trst_n)
         (state_r == tap_pkg::SH_DR && ir_r == tap_pkg::OP_BYPASS) |=> byp_r == $past(tdi);
   endproperty
   a_byp_one: assert property (p_byp_one) else $error("bypass is not one stage");

   property p_undef_byp;
      @(posedge tck) disable iff (!trst_n) ir_r == 4'h7 |-> mode_r.sel_byp && !mode_r.drive;
   endproperty
   a_undef_byp: assert property (p_undef_byp) else $error("undefined opcode not bypass");

   property p_clamp;
      @(posedge tck) disable iff (!trst_n) ir_r == tap_pkg::OP_CLAMP |-> mode_r.sel_byp && mode_r.drive;
   endproperty
   a_clamp: assert property (p_clamp) else $error("clamp decode wrong");

   property p_sample_quiet;
      @(posedge tck) disable iff (!trst_n)
         ir_r == tap_pkg::OP_SAMPLE |-> mode_r.sel_bsr && !mode_r.drive && !mode_r.intest;
   endproperty
   a_sample_quiet: assert property (p_sample_quiet) else $error("sample disturbs function");

   property p_preload;
      @(posedge tck) disable iff (!trst_n)
         (state_r == tap_pkg::UPD_DR && ir_r == tap_pkg::OP_SAMPLE) |=> bsr_upd_r == $past(bsr_sh_r) && tog_r != $past(tog_r);
   endproperty
   a_preload: assert property (p_preload) else $error("preload not latched");

   property p_oe;
      @(posedge tck) disable iff (!trst_n) 1'b1 |-> tdo_oe == shifting;
   endproperty
   a_oe: assert property (p_oe) else $error("data out enable not tied to shifting");

   property p_drive;
      @(posedge ref_clk) disable iff (!rstn) (ce && mode_s[1]) |=> pad_out_r == $past(hold_r[L-1:N_IN]);
   endproperty
   a_drive: assert property (p_drive) else $error("pins not driven from boundary cells");

   c_id_shift: cover property (@(posedge tck) disable iff (!trst_n) state_r == tap_pkg::SH_DR && ir_r == tap_pkg::OP_IDCODE);
   c_extest: cover property (@(posedge tck) disable iff (!trst_n) state_r == tap_pkg::UPD_DR && ir_r == tap_pkg::OP_EXTEST);
   c_byp: cover property (@(posedge tck) disable iff (!trst_n) state_r == tap_pkg::SH_DR && mode_r.sel_byp);
   c_pins: cover property (@(posedge ref_clk) disable iff (!rstn) mode_s[1] && tog_s != tog_d_r);

endmodule

// ### verification/tap_tester.sv
`timescale 1ns/100ps
// ****************************************
// Board tester model
// ****************************************
module tap_tester (
   output logic      tck,
   output logic      trst_n,
   output logic      tms,
   output logic      tdi,
   input  wire logic tdo,
   input  wire logic tdo_oe
);
   // Held in reset until the bench takes over
   initial begin
      tck    = 1'b0;
      trst_n = 1'b1;
      tms    = 1'b1;
      tdi    = 1'b0;
      // A real falling edge, so the asynchronous reset cannot be missed
      #1;
      trst_n = 1'b0;
   end

   // Clock stands low between steps; tms and tdi change only while it is low
   task automatic step(input logic m, input logic d, output logic q, output logic oe);
      tms = m;
      tdi = d;
      #7.5;
      q   = tdo;
      oe  = tdo_oe;
      tck = 1'b1;
      #7.5;
      tck = 1'b0;
   endtask

   // Outside shifting tdi toggles so a stale value is never mistaken for data
   task automatic idle(input logic m);
      logic q;
      logic oe;
      step(m, ~tdi, q, oe);
   endtask

   // No clock while reset is low
   task automatic test_reset(output logic oe_low, output logic tdo_low);
      trst_n = 1'b0;
      #3;
      oe_low  = tdo_oe;
      tdo_low = tdo;
      #17;
      trst_n = 1'b1;
      #5;
   endtask

   // Starts and ends in run-test-idle; the last bit leaves the shift state
   task automatic scan(input logic ir, input int w, input logic [63:0] din,
                       output logic [63:0] dout, output logic oe_all);
      logic q;
      logic oe;
      dout   = '0;
      oe_all = 1'b1;
      idle(1'b0);
      idle(1'b1);
      if (ir) begin
         idle(1'b1);
      end
      idle(1'b0);
      idle(1'b0);
      for (int i = 0; i < w; i++) begin
         step(i == w - 1, din[i], q, oe);
         dout[i] = q;
         oe_all  = oe_all & oe;
      end
      idle(1'b1);
      idle(1'b0);
   endtask
endmodule

// ### verification/boundary_scan_tap_test.sv
`timescale 1ns/100ps
module boundary_scan_tap_test;
   // Arbitrary identification values
   localparam logic [3:0]  VER    = 4'hA;
   localparam logic [15:0] PART   = 16'h5C3E;
   localparam logic [10:0] MAKR   = 11'h2B5;
   localparam logic [31:0] ID_EXP = {VER, PART, MAKR, 1'h1};

   logic        ref_clk = 1'b0;
   logic        rstn    = 1'b0;
   logic        ce      = 1'b0;
   logic [7:0]  pad_in  = 8'h00;
   logic [7:0]  core_out = 8'h00;
   logic        tck, trst_n, tms, tdi, tdo, tdo_oe;
   logic [7:0]  core_in, pad_out;
   logic [15:0] upd  = 16'h0000;
   logic [7:0]  priv = tap_pkg::PRIV_RESET;
   int          seed = 43168;
   int          miscompares  = 0;
   int          total_checks = 0;

   always #2 ref_clk = ~ref_clk;

   boundary_scan_tap #(.ID_VER(VER), .ID_PART(PART), .ID_MAKR(MAKR)) i_dut (
      .ref_clk(ref_clk), .rstn(rstn), .ce(ce), .tck(tck), .trst_n(trst_n), .tms(tms), .tdi(tdi),
      .tdo(tdo), .tdo_oe(tdo_oe), .pad_in(pad_in), .core_out(core_out), .core_in(core_in),
      .pad_out(pad_out));

   tap_tester i_tester (.tck(tck), .trst_n(trst_n), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));

   // ****************************************
   // Checking and verdict
   // ****************************************
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   task automatic conclude();
      $display("checks %0d miscompares %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   function automatic int dr_len(input logic [3:0] op);
      case (op)
         tap_pkg::OP_EXTEST, tap_pkg::OP_SAMPLE, tap_pkg::OP_INTEST: return 16;
         tap_pkg::OP_IDCODE:  return tap_pkg::ID_W;
         tap_pkg::OP_PRIVATE: return tap_pkg::PRIV_W;
         default:             return 1;
      endcase
   endfunction

   // ****************************************
   // Tests
   // ****************************************
   initial begin
      logic [63:0] din, dout, cap;
      logic [3:0]  op;
      logic        oe, tlow, drv, itst;
      int          len;
      repeat (8) @(posedge ref_clk);
      @(negedge ref_clk);
      rstn = 1'b1;
      ce   = 1'b1;
      i_tester.test_reset(oe, tlow);
      din = {$random(seed), $random(seed)};
      i_tester.scan(1'b0, 40, din, dout, oe);
      check(dout[39:0], {din[7:0], ID_EXP});
      check(oe, 1'b1);
      @(negedge ref_clk);
      check({tdo_oe, tdo}, 2'h0);
      $display("test identification after reset done");

      // Opcode order puts each preload ahead of the test that uses it
      for (int k = 0; k < 32; k++) begin
         op = 4'(k) ^ 4'h1;
         @(negedge ref_clk);
         pad_in   = $random(seed);
         core_out = $random(seed);
         i_tester.scan(1'b1, 4, {60'h0, op}, dout, oe);
         check(dout[3:0], tap_pkg::IR_CAPTURE);
         len  = dr_len(op);
         drv  = (op == tap_pkg::OP_EXTEST) || (op == tap_pkg::OP_CLAMP);
         itst = (op == tap_pkg::OP_INTEST);
         case (len)
            16:      cap = {48'h0, drv ? upd[15:8] : core_out, pad_in};
            32:      cap = {32'h0, ID_EXP};
            8:       cap = {56'h0, priv};
            default: cap = {63'h0, tap_pkg::BYP_CAPT};
         endcase
         din = {$random(seed), $random(seed)};
         i_tester.scan(1'b0, 40, din, dout, oe);
         check(dout[39:0], 40'(cap | (din << len)));
         if (len == 16) begin
            upd = din[39:24];
         end
         if (len == 8) begin
            priv = din[39:32];
         end
         repeat (20) @(negedge ref_clk);
         check(pad_out, drv ? upd[15:8] : core_out);
         check(core_in, itst ? upd[7:0] : pad_in);
      end
      $display("test instruction sweep done");

      // Enable low freezes the pin paths; then a functional reset mid-run
      @(negedge ref_clk);
      ce       = 1'b0;
      pad_in   = ~pad_in;
      core_out = ~core_out;
      repeat (10) @(negedge ref_clk);
      check({pad_out, core_in}, {~core_out, ~pad_in});
      rstn = 1'b0;
      repeat (3) @(negedge ref_clk);
      check({pad_out, core_in}, 16'h0000);
      rstn = 1'b1;
      ce   = 1'b1;
      repeat (10) @(negedge ref_clk);
      check({pad_out, core_in}, {core_out, pad_in});
      $display("test enable and functional reset done");

      // Reset pulled in mid-shift with the clock standing still
      i_tester.idle(1'b0);
      i_tester.idle(1'b1);
      repeat (4) i_tester.idle(1'b0);
      @(negedge ref_clk);
      check(tdo_oe, 1'b1);
      i_tester.test_reset(oe, tlow);
      check({oe, tlow}, 2'h0);
      din = {$random(seed), $random(seed)};
      i_tester.scan(1'b0, 40, din, dout, oe);
      check(dout[39:0], {din[7:0], ID_EXP});
      $display("test reset during shift done");
      conclude();
   end

   initial begin
      #200000;
      miscompares++;
      conclude();
   end
endmodule
